/* File: rtl/xis_regs.svh */
/*
 * Constants of the extended stack instruction decoder: opcodes, fields,
 * reset values and the indirect-access address window.
 * Assumes a 12-bit data address space and a 21-bit program counter.
 */
`ifndef XIS_REGS_SVH
`define XIS_REGS_SVH

`define XIS_OP_ADD_PTR    8'he8
`define XIS_OP_SUB_PTR    8'he9
`define XIS_OP_PUSH_LIT   8'hea
`define XIS_OP_MOVE_IDX   8'heb
`define XIS_OP_CALL_WORK  16'h0014
`define XIS_SEL_RETURN    2'h3
`define XIS_STACK_PTR     2'h2
`define XIS_RET_STEP      21'h000002
`define XIS_PTR_RST       12'h000
`define XIS_PC_RST        21'h000000

// Indirect-access registers: page f, five per pointer from each base
`define XIS_IND_PAGE      4'hf
`define XIS_IND_BASE0     8'heb
`define XIS_IND_BASE1     8'he3
`define XIS_IND_BASE2     8'hdb
`define XIS_IND_SPAN      8'h04

`endif

/* File: rtl/xis_pkg.sv */
/*
 * Types of the extended stack instruction decoder.
 * Assumes xis_regs.svh is on the include path.
 */
package xis_pkg;

	typedef enum logic [3:0] {
		XIS_ST_IDLE    = 4'b0001,
		XIS_ST_MOVE2   = 4'b0010,
		XIS_ST_MOVE_WR = 4'b0100,
		XIS_ST_NOP     = 4'b1000
	} xis_state_e;

	typedef struct packed {
		logic        valid;
		logic [20:0] addr;
	} xis_pc_s;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [11:0] addr;
		logic [7:0]  data;
	} xis_mem_s;

endpackage : xis_pkg

/* File: rtl/xis_agen.sv */
/*
 * Indexed address generator: stack pointer plus 7-bit offset, with a flag
 * for addresses that land on an indirect-access register.
 * Purely combinational; the caller registers what it needs.
 */
`timescale 1ns/1ns
`default_nettype none
`include "xis_regs.svh"

module xis_agen (
	input  wire logic [11:0] base,     // Stack pointer value
	input  wire logic [6:0]  offset,   // Unsigned offset
	output logic      [11:0] addr,     // Resulting data address
	output logic             indirect  // Address is an indirect register
);

	function automatic logic in_win(input logic [7:0] lo, input logic [7:0] b);
		in_win = (lo >= b) && (lo <= 8'(b + `XIS_IND_SPAN));
	endfunction : in_win

	// Wraps in 12 bits
	assign addr = 12'(base + {5'h00, offset});
	assign indirect = (addr[11:8] == `XIS_IND_PAGE)
		&& (in_win(addr[7:0], `XIS_IND_BASE0) || in_win(addr[7:0], `XIS_IND_BASE1)
		|| in_win(addr[7:0], `XIS_IND_BASE2));

endmodule : xis_agen

`default_nettype wire

/* File: rtl/xis_decoder.sv */
/*
 * Extended stack instruction decoder: decodes and executes the five
 * extended instructions, owns the three pointer registers.
 * Assumes a same-clock fetch path, a data memory that returns read data the
 * cycle after a read request is presented, and a core that ignores its own
 * decode while ext_hit_q or busy_q is high.
 */
`timescale 1ns/1ns
`default_nettype none
`include "xis_regs.svh"

module xis_decoder (
	input  wire logic                   clk_sys,       // Core clock
	input  wire logic                   rst_n,         // Async reset, low
	input  wire logic                   ext_enable,    // Extended set enable bit
	input  wire logic                   instr_valid,   // Instruction word present
	input  wire logic [15:0]            instr,         // Instruction word
	input  wire logic [20:0]            pc_cur,        // Counter of current word
	input  wire logic [7:0]             work_reg,      // Working register
	input  wire logic [7:0]             pc_hi_latch,   // Counter high latch
	input  wire logic [7:0]             pc_up_latch,   // Counter upper latch
	input  wire logic [20:0]            ret_top,       // Return stack top
	input  wire logic [7:0]             mem_rdata,     // Data memory read data
	output var  logic [2:0][11:0]       ptr_q,         // Pointer registers 0..2
	output var  xis_pkg::xis_pc_s       pc_load_q,     // Counter load request
	output var  xis_pkg::xis_pc_s       ret_push_q,    // Return stack push
	output var  logic                   ret_pop_q,     // Return stack pop
	output var  xis_pkg::xis_mem_s      mem_req_q,     // Data memory request
	output var  logic                   ext_hit_q,     // Extended op accepted
	output var  logic                   busy_q         // Later cycles pending
);
	import xis_pkg::*;

	xis_state_e       state_q, state_d;
	logic [2:0][11:0] ptr_d;
	xis_pc_s          pc_load_d, ret_push_d;
	xis_mem_s         mem_req_d;
	logic             ret_pop_d;
	logic             idx_mode_q, idx_mode_d;
	logic             src_ind_q, src_ind_d;
	logic             dst_ind_q, dst_ind_d;
	logic [11:0]      dst_q, dst_d;

	function automatic logic [11:0] ptr_step(input logic [11:0] p,
		input logic [5:0] k, input logic sub);
		// Carry and borrow above bit 11 are dropped
		ptr_step = sub ? 12'(p - {6'h00, k}) : 12'(p + {6'h00, k});
	endfunction : ptr_step

	wire       idle      = (state_q == XIS_ST_IDLE);
	wire       take      = instr_valid && ext_enable && idle;
	wire       is_add    = (instr[15:8] == `XIS_OP_ADD_PTR);
	wire       is_sub    = (instr[15:8] == `XIS_OP_SUB_PTR);
	wire       is_push   = (instr[15:8] == `XIS_OP_PUSH_LIT);
	wire       is_move   = (instr[15:8] == `XIS_OP_MOVE_IDX);
	wire       is_call   = (instr == `XIS_OP_CALL_WORK);
	wire [1:0] sel       = instr[7:6];
	wire [5:0] lit6      = instr[5:0];
	wire       is_ret    = (sel == `XIS_SEL_RETURN);
	// Select 3 is redirected to the stack pointer
	wire [1:0] ptr_idx   = is_ret ? `XIS_STACK_PTR : sel;
	wire       is_ext    = is_add || is_sub || is_push || is_move || is_call;

	logic [11:0] idx_addr;
	logic        idx_ind;

	// Both words keep their offset in bits 6:0 and pointer 2 is stable between them
	xis_agen xis_agen_i (
		.base     (ptr_q[`XIS_STACK_PTR]),
		.offset   (instr[6:0]),
		.addr     (idx_addr),
		.indirect (idx_ind)
	);

	// Status flags have no path out of this block
	always_comb begin
		state_d    = state_q;
		ptr_d      = ptr_q;
		pc_load_d  = '0;
		ret_push_d = '0;
		ret_pop_d  = 1'b0;
		mem_req_d  = '0;
		idx_mode_d = idx_mode_q;
		src_ind_d  = src_ind_q;
		dst_ind_d  = dst_ind_q;
		dst_d      = dst_q;
		case (state_q)
			XIS_ST_IDLE: begin
				if (take && (is_add || is_sub)) begin
					ptr_d[ptr_idx] = ptr_step(ptr_q[ptr_idx], lit6, is_sub);
					if (is_ret) begin
						pc_load_d = '{valid: 1'b1, addr: ret_top};
						ret_pop_d = 1'b1;
						state_d   = XIS_ST_NOP;
					end
				end else if (take && is_push) begin
					mem_req_d = '{valid: 1'b1, we: 1'b1,
						addr: ptr_q[`XIS_STACK_PTR], data: instr[7:0]};
					ptr_d[`XIS_STACK_PTR] = ptr_step(ptr_q[`XIS_STACK_PTR], 6'h01, 1'b1);
				end else if (take && is_call) begin
					ret_push_d = '{valid: 1'b1, addr: 21'(pc_cur + `XIS_RET_STEP)};
					pc_load_d  = '{valid: 1'b1,
						addr: {pc_up_latch[4:0], pc_hi_latch, work_reg}};
					state_d    = XIS_ST_NOP;
				end else if (take && is_move) begin
					mem_req_d  = '{valid: 1'b1, we: 1'b0, addr: idx_addr, data: 8'h00};
					src_ind_d  = idx_ind;
					idx_mode_d = instr[7];
					state_d    = XIS_ST_MOVE2;
				end
			end
			XIS_ST_MOVE2: begin
				// Second word carries the destination
				if (instr_valid) begin
					dst_d     = idx_mode_q ? idx_addr : instr[11:0];
					dst_ind_d = idx_mode_q && idx_ind;
					state_d   = XIS_ST_MOVE_WR;
				end
			end
			XIS_ST_MOVE_WR: begin
				// An indirect destination in indexed mode turns the write into a no-operation
				mem_req_d = '{valid: !dst_ind_q, we: 1'b1, addr: dst_q,
					data: src_ind_q ? 8'h00 : mem_rdata};
				state_d   = XIS_ST_IDLE;
			end
			XIS_ST_NOP: begin
				// Discarded fetch slot while the new counter takes effect
				state_d = XIS_ST_IDLE;
			end
			default: begin
				state_d = XIS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_q    <= XIS_ST_IDLE;
			ptr_q      <= {3{`XIS_PTR_RST}};
			pc_load_q  <= '0;
			ret_push_q <= '0;
			ret_pop_q  <= 1'b0;
			mem_req_q  <= '0;
			ext_hit_q  <= 1'b0;
			busy_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			ptr_q      <= ptr_d;
			pc_load_q  <= pc_load_d;
			ret_push_q <= ret_push_d;
			ret_pop_q  <= ret_pop_d;
			mem_req_q  <= mem_req_d;
			ext_hit_q  <= take && is_ext;
			busy_q     <= (state_d != XIS_ST_IDLE);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			idx_mode_q <= 1'b0;
			src_ind_q  <= 1'b0;
			dst_ind_q  <= 1'b0;
			dst_q      <= `XIS_PTR_RST;
		end else begin
			idx_mode_q <= idx_mode_d;
			src_ind_q  <= src_ind_d;
			dst_ind_q  <= dst_ind_d;
			dst_q      <= dst_d;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_add_ptr;
		take && is_add && !is_ret |=>
			ptr_q[$past(sel)] == 12'($past(ptr_q[sel]) + $past(lit6));
	endproperty
	a_add_ptr: assert property (p_add_ptr) else $error("pointer add wrong");

	property p_ret_two;
		take && (is_add || is_sub) && is_ret |=>
			pc_load_q.valid && ret_pop_q && pc_load_q.addr == $past(ret_top)
			##1 !pc_load_q.valid && busy_q == 1'b0;
	endproperty
	a_ret_two: assert property (p_ret_two) else $error("return form timing wrong");

	property p_ret_only2;
		take && (is_add || is_sub) && is_ret |=>
			ptr_q[0] == $past(ptr_q[0]) && ptr_q[1] == $past(ptr_q[1]);
	endproperty
	a_ret_only2: assert property (p_ret_only2) else $error("return form hit pointer 0/1");

	property p_sub_ptr;
		take && is_sub |=> ptr_q[$past(ptr_idx)] ==
			12'($past(ptr_q[ptr_idx]) - $past(lit6));
	endproperty
	a_sub_ptr: assert property (p_sub_ptr) else $error("pointer subtract wrong");

	property p_call;
		take && is_call |=> ret_push_q.valid
			&& ret_push_q.addr == 21'($past(pc_cur) + 21'h000002)
			&& pc_load_q.addr[7:0] == $past(work_reg) ##1 !busy_q;
	endproperty
	a_call: assert property (p_call) else $error("call via work register wrong");

	// Read must address pointer 2 plus offset; nothing is issued while word 2 is pending
	property p_move;
		take && is_move |=> mem_req_q.valid && !mem_req_q.we && busy_q
			&& mem_req_q.addr == 12'($past(ptr_q[2]) + {5'h00, $past(instr[6:0])})
			##1 busy_q && !mem_req_q.valid;
	endproperty
	a_move: assert property (p_move) else $error("move first word wrong");

	property p_push;
		take && is_push |=> mem_req_q.we && mem_req_q.data == $past(instr[7:0])
			&& ptr_q[2] == 12'($past(ptr_q[2]) - 12'h001);
	endproperty
	a_push: assert property (p_push) else $error("push literal wrong");

	property p_disabled;
		instr_valid && !ext_enable && idle |=> !ext_hit_q && !mem_req_q.valid;
	endproperty
	a_disabled: assert property (p_disabled) else $error("ran while disabled");

	property p_ind_zero;
		state_q == XIS_ST_MOVE_WR && src_ind_q && !dst_ind_q |=> mem_req_q.data == 8'h00;
	endproperty
	a_ind_zero: assert property (p_ind_zero) else $error("indirect source not zero");

endmodule : xis_decoder

`default_nettype wire

/* File: bench/test_extended_stack_instruction_decoder.sv */
/* Self-checking bench of the extended stack instruction decoder.
   Assumes the rtl/ files and xis_regs.svh on the include path. */
`timescale 1ns/1ns
`default_nettype none
`include "xis_regs.svh"
module test_extended_stack_instruction_decoder;
	import xis_pkg::*;
	logic             clk_sys     = 1'b0;
	logic             rst_n       = 1'b0;
	logic             ext_enable  = 1'b1;
	logic             instr_valid = 1'b0;
	logic [15:0]      instr       = 16'h0000;
	logic [20:0]      pc_cur      = 21'h000000;
	logic [7:0]       work_reg    = 8'h00;
	logic [7:0]       pc_hi_latch = 8'h00;
	logic [7:0]       pc_up_latch = 8'h00;
	logic [20:0]      ret_top     = 21'h000000;
	logic [7:0]       mem_rdata   = 8'h00;
	logic [2:0][11:0] ptr_q;
	xis_pc_s          pc_load_q;
	xis_pc_s          ret_push_q;
	logic             ret_pop_q;
	xis_mem_s         mem_req_q;
	logic             ext_hit_q;
	logic             busy_q;
	logic [11:0]      ptr_m [3];
	logic [5:0]       k;
	logic [1:0]       sel;
	logic             sub;
	logic             en;
	int               error_cnt = 0;
	int               n_checks  = 0;
	int               cyc       = 0;

	always #5 clk_sys = ~clk_sys;

	xis_decoder xis_decoder_i (
		.clk_sys(clk_sys), .rst_n(rst_n), .ext_enable(ext_enable),
		.instr_valid(instr_valid), .instr(instr), .pc_cur(pc_cur),
		.work_reg(work_reg), .pc_hi_latch(pc_hi_latch), .pc_up_latch(pc_up_latch),
		.ret_top(ret_top), .mem_rdata(mem_rdata), .ptr_q(ptr_q),
		.pc_load_q(pc_load_q), .ret_push_q(ret_push_q), .ret_pop_q(ret_pop_q),
		.mem_req_q(mem_req_q), .ext_hit_q(ext_hit_q), .busy_q(busy_q)
	);

	task automatic test_done;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done

	// Whole run is well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_ptr;
		chk({12'h000, ptr_q}, {12'h000, ptr_m[2], ptr_m[1], ptr_m[0]});
	endtask : chk_ptr

	// Valid stays high so words can go back to back
	task automatic issue(input logic [15:0] w);
		instr_valid = 1'b1;
		instr = w;
		@(posedge clk_sys);
		#1;
	endtask : issue

	task automatic idle;
		instr_valid = 1'b0;
		@(posedge clk_sys);
		#1;
	endtask : idle

	function automatic logic [11:0] arith(input logic [11:0] p, input logic [5:0] kk,
		input logic s);
		return s ? p - {6'h00, kk} : p + {6'h00, kk};
	endfunction : arith

	function automatic logic ind(input logic [7:0] lo, input logic [3:0] pg);
		return pg == `XIS_IND_PAGE && ((lo - `XIS_IND_BASE0) <= `XIS_IND_SPAN
			|| (lo - `XIS_IND_BASE1) <= `XIS_IND_SPAN || (lo - `XIS_IND_BASE2) <= `XIS_IND_SPAN);
	endfunction : ind

	task automatic push(input logic [7:0] kk);
		issue({8'hea, kk});
		chk(mem_req_q, {1'b1, 1'b1, ptr_m[2], kk});
		ptr_m[2] = ptr_m[2] - 12'h001;
		chk_ptr();
	endtask : push

	task automatic move(input logic idx, input logic [6:0] zs, input logic [11:0] w2,
		input logic [7:0] d);
		logic [11:0] src;
		logic [11:0] dst;
		src = ptr_m[2] + {5'h00, zs};
		dst = idx ? ptr_m[2] + {5'h00, w2[6:0]} : w2;
		issue({8'heb, idx, zs});
		chk({busy_q, mem_req_q[21:8]}, {3'b110, src});
		mem_rdata = d;
		issue({4'hf, w2});
		idle();
		if (idx && ind(dst[7:0], dst[11:8])) begin
			chk(mem_req_q.valid, 1'b0);
		end else begin
			chk(mem_req_q, {2'b11, dst, ind(src[7:0], src[11:8]) ? 8'h00 : d});
		end
		chk({busy_q, ptr_q[2]}, {1'b0, ptr_m[2]});
	endtask : move

	initial begin
		void'($urandom(32'h1b55d852));
		ptr_m = '{default: 12'h000};
		repeat (6) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		push(8'h5a);
		// Pointer 2 now lands on an indirect register
		issue({8'he9, 2'b10, 6'h14});
		ptr_m[2] = 12'hfeb;
		chk_ptr();
		move(1'b1, 7'h00, 12'h010, 8'h77);
		move(1'b1, 7'h00, 12'h002, 8'h77);
		repeat (200) begin
			sub = 1'($urandom);
			sel = 2'($urandom_range(0, 2));
			k = 6'($urandom);
			en = 1'($urandom);
			ext_enable = en;
			issue({7'b1110100, sub, sel, k});
			if (en) ptr_m[sel] = arith(ptr_m[sel], k, sub);
			chk(ext_hit_q, en);
			chk_ptr();
		end
		ext_enable = 1'b1;
		for (int s = 0; s < 2; s++) begin
			k = 6'($urandom);
			ret_top = 21'($urandom);
			issue({7'b1110100, s[0], 2'b11, k});
			ptr_m[2] = arith(ptr_m[2], k, s[0]);
			chk(pc_load_q, {1'b1, ret_top});
			chk({ret_pop_q, busy_q}, 2'b11);
			chk_ptr();
			issue(16'he83f);
			chk({ext_hit_q, pc_load_q.valid, ret_pop_q}, 3'b000);
			chk_ptr();
			idle();
		end
		pc_cur = 21'($urandom);
		work_reg = 8'($urandom);
		pc_hi_latch = 8'($urandom);
		pc_up_latch = 8'($urandom);
		issue(16'h0014);
		chk(ret_push_q, {1'b1, pc_cur + 21'h000002});
		chk(pc_load_q, {1'b1, pc_up_latch[4:0], pc_hi_latch, work_reg});
		chk(busy_q, 1'b1);
		idle();
		chk({ret_push_q.valid, pc_load_q.valid}, 2'b00);
		idle();
		repeat (8) begin
			move(1'($urandom), 7'($urandom), 12'($urandom), 8'($urandom));
		end
		test_done();
	end
endmodule : test_extended_stack_instruction_decoder
`default_nettype wire
